//--- core/cdt_top.sv
// Purpose: Clock doubler and two-phase generator, digital model
// Assumes: Reference period well above the step count in CLK cycles
// Notes:   Grade and status reached over AHB-Lite; modes are pins
//
// Contract
// - Outputs 0,1 at 1X; 2,3 at 2X
// - True 1X output aligned to reference
// - Inverted output is complement of copy
// - Inversion pin low inverts output one
// - Two-phase enable turns outputs 4,5 into phases
// - Phases never overlap, stay synchronous
// - Any fixed feedback delay tolerated
// - Keep feedback rising aligned to reference
// - Lock within 500 us after start
// - Test select steps from test clock
// - 25 MHz grade: 16 pulses per cycle
// - 20, 12, 8, 8 pulses for other grades
// - Starting state reached within 16 pulses; the 20 MHz grade has 20 steps per cycle and can need more
// - Test clock single-stepped or free running
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cdt_params.svh"
module cdt_top #(
  parameter int SYNC_CYCLES = (`CDT_SYNC_TIME_US * 1000) / `CDT_CLK_PERIOD_NS
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        REFERENCE_CLOCK_IN,
  input  wire logic        FEEDBACK_IN,
  input  wire logic        TWO_PHASE_ENABLE,
  input  wire logic        INVERT_OUT1_N,
  input  wire logic        TEST_SELECT,
  input  wire logic        TEST_STEP_CLOCK,
  output      logic        OUT_CLK_0,
  output      logic        OUT_CLK_1,
  output      logic        OUT_CLK_2,
  output      logic        OUT_CLK_3,
  output      logic        OUT_CLK_4,
  output      logic        OUT_CLK_5,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output      logic        HREADYOUT,
  output      logic [31:0] HRDATA,
  output      logic        HRESP
);
  logic                    rst_meta_ff;
  logic                    rst_sync_ff;
  logic                    rst_n;
  // Pin order: ref, fb, step clock, two-phase, invert, test select
  logic [5:0]              pin_a_ff;
  logic [5:0]              pin_b_ff;
  logic [5:0]              pins;
  logic                    ref_d_ff;
  logic                    fb_d_ff;
  logic                    tck_d_ff;
  logic                    ref_rise;
  logic                    fb_rise;
  logic                    test_rise;
  logic                    test_mode;
  logic [15:0]             ref_age_ff;
  logic [15:0]             period_ff;
  logic                    ref_lost;
  logic [15:0]             acc_ff;
  logic [15:0]             nxt_acc;
  logic [16:0]             acc_sum;
  logic                    osc_step;
  logic                    step;
  logic [5:0]              n_steps;
  cdt_pkg::cdt_grade_type  grade_ff;
  cdt_pkg::cdt_adjust_type adj;
  cdt_pkg::cdt_clocks_type clocks;
  logic                    locked;
  logic                    sync_late;
  logic                    ap_valid_ff;
  logic                    ap_write_ff;
  logic [7:0]              ap_addr_ff;
  logic                    ap_take;
  logic                    cfg_write;
  logic [2:0]              cfg_view;
  logic [31:0]             rd_mux;
  logic [31:0]             hrdata_ff;
  logic                    hreadyout_ff;

  function automatic logic [5:0] steps_of(input cdt_pkg::cdt_grade_type g);
    logic [5:0] s;
    unique case (g)
      `CDT_GRADE_20: s = `CDT_STEPS_20;
      `CDT_GRADE_25: s = `CDT_STEPS_25;
      `CDT_GRADE_33: s = `CDT_STEPS_33;
      `CDT_GRADE_40: s = `CDT_STEPS_40;
      default:       s = `CDT_STEPS_50;
    endcase
    return s;
  endfunction : steps_of

  function automatic logic grade_ok(input logic [2:0] g);
    return g <= `CDT_GRADE_50;
  endfunction : grade_ok

  // Reset release through two flops
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // Each of the six sampled pins is asynchronous to CLK
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_a_ff <= 6'h00;
      pin_b_ff <= 6'h00;
      ref_d_ff <= 1'b0;
      fb_d_ff  <= 1'b0;
      tck_d_ff <= 1'b0;
    end
    else
    begin
      pin_a_ff <= {TEST_SELECT, INVERT_OUT1_N, TWO_PHASE_ENABLE,
                   TEST_STEP_CLOCK, FEEDBACK_IN, REFERENCE_CLOCK_IN};
      pin_b_ff <= pin_a_ff;
      ref_d_ff <= pin_b_ff[0];
      fb_d_ff  <= pin_b_ff[1];
      tck_d_ff <= pin_b_ff[2];
    end
  end
  assign pins      = pin_b_ff;
  assign ref_rise  = pins[0] & ~ref_d_ff;
  assign fb_rise   = pins[1] & ~fb_d_ff;
  // Edge by edge, so single steps work; rate bound by sampling
  assign test_rise = pins[2] & ~tck_d_ff;
  assign test_mode = pins[5];

  // Reference period measured in CLK cycles
  assign ref_lost = (ref_age_ff == `CDT_AGE_MAX);
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_age_ff <= `CDT_AGE_MAX;
      period_ff  <= 16'h0000;
    end
    else
    begin
      if (ref_rise)
        ref_age_ff <= 16'h0000;
      else if (!ref_lost)
        ref_age_ff <= ref_age_ff + 16'h0001;
      if (ref_rise && !ref_lost)
        period_ff <= ref_age_ff + 16'h0001;
      else if (ref_lost)
        period_ff <= 16'h0000;
    end
  end

  // Internal oscillator: n_steps evenly spread over one period
  assign n_steps  = steps_of(grade_ff);
  assign acc_sum  = {1'b0, acc_ff} + {11'h000, n_steps};
  assign osc_step = (period_ff != 16'h0000) && (acc_sum >= {1'b0, period_ff});
  assign nxt_acc  = (test_mode || period_ff == 16'h0000) ? 16'h0000 :
                    osc_step ? 16'(acc_sum - {1'b0, period_ff}) : acc_sum[15:0];
  assign step     = test_mode ? test_rise : osc_step;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      acc_ff <= 16'h0000;
    else
      acc_ff <= nxt_acc;
  end

  cdt_phase_gen u_phase (
    .clk              (CLK),
    .rst_n            (rst_n),
    .step             (step),
    .n_steps          (n_steps),
    .two_phase_enable (pins[3]),
    .invert_out1_n    (pins[4]),
    .adj              (adj),
    .clocks           (clocks)
  );

  // Relies on a free-running 1X copy on the feedback pin
  cdt_lock_mon #(
    .SYNC_CYCLES (SYNC_CYCLES)
  ) u_lock (
    .clk       (CLK),
    .rst_n     (rst_n),
    .ref_rise  (ref_rise),
    .fb_rise   (fb_rise),
    .ref_age   (ref_age_ff),
    .half      (period_ff >> 1),
    .ref_lost  (ref_lost),
    .test_mode (test_mode),
    .adj       (adj),
    .locked    (locked),
    .sync_late (sync_late)
  );

  assign OUT_CLK_0 = clocks.c0;
  assign OUT_CLK_1 = clocks.c1;
  assign OUT_CLK_2 = clocks.c2;
  assign OUT_CLK_3 = clocks.c3;
  assign OUT_CLK_4 = clocks.c4;
  assign OUT_CLK_5 = clocks.c5;

  // AHB-Lite slave, zero wait states
  assign ap_take   = HSEL & HTRANS[`CDT_HTRANS_ACT_BIT] & HREADY;
  assign cfg_write = ap_valid_ff & ap_write_ff & (ap_addr_ff == `CDT_ADDR_CONFIG) &
                     grade_ok(HWDATA[2:0]);
  // Forward a write in flight so a following read sees it
  assign cfg_view  = cfg_write ? HWDATA[2:0] : grade_ff;
  assign rd_mux    = (HADDR[7:0] == `CDT_ADDR_CONFIG) ? {29'h0, cfg_view} :
                     (HADDR[7:0] == `CDT_ADDR_STATUS) ?
                       {18'h0, clocks, 5'h0, test_mode, sync_late, locked} :
                     (HADDR[7:0] == `CDT_ADDR_PERIOD) ? {16'h0, period_ff} : 32'h0;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap_valid_ff  <= 1'b0;
      ap_write_ff  <= 1'b0;
      ap_addr_ff   <= 8'h00;
      grade_ff     <= `CDT_GRADE_RST;
      hrdata_ff    <= 32'h0;
      hreadyout_ff <= 1'b0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      if (HREADY)
      begin
        ap_valid_ff <= ap_take;
        ap_write_ff <= HWRITE;
        ap_addr_ff  <= HADDR[7:0];
      end
      // Illegal grade codes are dropped
      if (cfg_write)
        grade_ff <= HWDATA[2:0];
      if (ap_take && !HWRITE)
        hrdata_ff <= rd_mux;
    end
  end

  assign HRDATA    = hrdata_ff;
  assign HREADYOUT = hreadyout_ff;
  assign HRESP     = 1'b0;
endmodule : cdt_top

//--- core/cdt_params.svh
// Purpose: Named constants for the clock doubler / two-phase generator
// Assumes: 100 MHz system clock, AHB-Lite register window
// Notes:   Types live in cdt_pkg
`ifndef CDT_PARAMS_SVH
`define CDT_PARAMS_SVH
`define CDT_ADDR_CONFIG     8'h00
`define CDT_ADDR_STATUS     8'h04
`define CDT_ADDR_PERIOD     8'h08
`define CDT_GRADE_20        3'h0
`define CDT_GRADE_25        3'h1
`define CDT_GRADE_33        3'h2
`define CDT_GRADE_40        3'h3
`define CDT_GRADE_50        3'h4
`define CDT_GRADE_RST       3'h1
`define CDT_STEPS_20        6'h14
`define CDT_STEPS_25        6'h10
`define CDT_STEPS_33        6'h0c
`define CDT_STEPS_40        6'h08
`define CDT_STEPS_50        6'h08
`define CDT_CLK_PERIOD_NS   10
`define CDT_SYNC_TIME_US    500
`define CDT_ALIGN_TOL       16'h0001
`define CDT_ALIGN_SHIFT     3
`define CDT_LOCK_EVENTS     4'h8
`define CDT_AGE_MAX         16'hffff
`define CDT_HTRANS_ACT_BIT  1
`endif

//--- core/cdt_pkg.sv
// Purpose: Shared types of the clock doubler
// Assumes: Nothing
// Notes:   Constants are macros in cdt_params.svh
package cdt_pkg;
  typedef logic [2:0] cdt_grade_type;
  typedef struct packed {
    logic c5;
    logic c4;
    logic c3;
    logic c2;
    logic c1;
    logic c0;
  } cdt_clocks_type;
  typedef struct packed {
    logic advance;
    logic retard;
  } cdt_adjust_type;
  typedef enum logic [1:0] {
    CDT_ACQUIRE,
    CDT_LOCKED
  } cdt_lock_state_type;
endpackage : cdt_pkg

//--- core/cdt_phase_gen.sv
// Purpose: Configuration state machine; divides steps into the six clocks
// Assumes: One step is one internal oscillator or test clock period
// Notes:   Phase zero is the predetermined starting state
`timescale 1ns/1ps
module cdt_phase_gen (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   step,
  input  wire logic [5:0]             n_steps,
  input  wire logic                   two_phase_enable,
  input  wire logic                   invert_out1_n,
  input  wire cdt_pkg::cdt_adjust_type adj,
  output      cdt_pkg::cdt_clocks_type clocks
);
  logic [5:0]              phase_ff;
  logic [5:0]              nxt_phase;
  logic [5:0]              n_ff;
  logic [5:0]              inc;
  logic [6:0]              sum;
  logic                    adv_ff;
  logic                    ret_ff;
  cdt_pkg::cdt_clocks_type clocks_ff;

  function automatic cdt_pkg::cdt_clocks_type wave(input logic [5:0] p,
                                                     input logic [5:0] n,
                                                     input logic en2,
                                                     input logic inv_n);
    logic [5:0]              h;
    logic [5:0]              q;
    logic [5:0]              ph;
    logic                    one;
    logic                    two;
    cdt_pkg::cdt_clocks_type w;
    h   = n >> 1;
    q   = n >> 2;
    ph  = (p >= h) ? p - h : p;
    w.c0 = p < h;
    w.c1 = inv_n ? w.c0 : ~w.c0;
    w.c2 = ph < q;
    w.c3 = ph < q;
    // One step of guard keeps the pair apart
    one = p < q - 6'h01;
    two = (p >= h) && (p < h + q - 6'h01);
    w.c4 = en2 ? one : w.c2;
    w.c5 = en2 ? two : w.c3;
    return w;
  endfunction : wave

  // Steering by one step is the phase-shift increment
  assign inc = !step ? 6'h00 : ret_ff ? 6'h00 : adv_ff ? 6'h02 : 6'h01;
  assign sum = {1'b0, phase_ff} + {1'b0, inc};
  // A new step count restarts the cycle, so no half-wave glitch
  assign nxt_phase = (phase_ff >= n_steps || n_steps != n_ff) ? 6'h00 :
                     (sum >= {1'b0, n_steps}) ? 6'(sum - {1'b0, n_steps}) : sum[5:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_ff  <= 6'h00;
      n_ff      <= 6'h00;
      adv_ff    <= 1'b0;
      ret_ff    <= 1'b0;
      clocks_ff <= '0;
    end
    else
    begin
      phase_ff  <= nxt_phase;
      n_ff      <= n_steps;
      adv_ff    <= adj.advance | (adv_ff & ~step);
      ret_ff    <= adj.retard | (ret_ff & ~step);
      clocks_ff <= wave(nxt_phase, n_steps, two_phase_enable, invert_out1_n);
    end
  end

  assign clocks = clocks_ff;
endmodule : cdt_phase_gen

//--- core/cdt_lock_mon.sv
// Purpose: Compares feedback to reference edges and tracks lock
// Assumes: Edge pulses come from synchronised pins
// Notes:   Any fixed feedback delay is absorbed by steering
`timescale 1ns/1ps
`include "cdt_params.svh"
module cdt_lock_mon #(
  parameter int SYNC_CYCLES = 50000
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ref_rise,
  input  wire logic                  fb_rise,
  input  wire logic [15:0]           ref_age,
  input  wire logic [15:0]           half,
  input  wire logic                  ref_lost,
  input  wire logic                  test_mode,
  output      cdt_pkg::cdt_adjust_type adj,
  output      logic                  locked,
  output      logic                  sync_late
);
  logic [15:0]                 fb_age_ff;
  logic [3:0]                  good_ff;
  logic [19:0]                 timer_ff;
  logic                        sync_late_ff;
  logic [15:0]                 tol;
  logic                        aligned;
  logic                        late;
  logic                        early;
  cdt_pkg::cdt_adjust_type     adj_ff;
  cdt_pkg::cdt_lock_state_type state_ff;
  cdt_pkg::cdt_lock_state_type nxt_state;

  // Steering moves a whole step, up to an eighth of a period;
  // a narrower window could never be reached for some delays
  assign tol     = (half >> `CDT_ALIGN_SHIFT) | `CDT_ALIGN_TOL;
  assign aligned = (fb_rise && ref_age <= tol) ||
                   (ref_rise && fb_age_ff <= tol);
  // Feedback behind reference: advance; ahead: retard
  assign late  = fb_rise && ref_age > tol && ref_age < half;
  assign early = ref_rise && fb_age_ff > tol && fb_age_ff < half;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      cdt_pkg::CDT_ACQUIRE: if (good_ff >= `CDT_LOCK_EVENTS) nxt_state = cdt_pkg::CDT_LOCKED;
      cdt_pkg::CDT_LOCKED:  if (ref_lost || test_mode) nxt_state = cdt_pkg::CDT_ACQUIRE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fb_age_ff    <= `CDT_AGE_MAX;
      good_ff      <= 4'h0;
      timer_ff     <= 20'h00000;
      sync_late_ff <= 1'b0;
      adj_ff       <= '0;
      state_ff     <= cdt_pkg::CDT_ACQUIRE;
    end
    else
    begin
      fb_age_ff <= fb_rise ? 16'h0000 :
                   (fb_age_ff == `CDT_AGE_MAX) ? fb_age_ff : fb_age_ff + 16'h0001;
      // Test mode bypasses the loop, so no steering
      adj_ff.advance <= late & ~test_mode;
      adj_ff.retard  <= early & ~test_mode;
      if (late || early || ref_lost || test_mode)
        good_ff <= 4'h0;
      else if (aligned && good_ff != 4'hf)
        good_ff <= good_ff + 4'h1;
      // Timer restarts while the reference is absent
      // Loop is bypassed in test mode, so lock time starts afresh after it
      if (ref_lost || test_mode || state_ff == cdt_pkg::CDT_LOCKED)
        timer_ff <= 20'h00000;
      else if (timer_ff < 20'(SYNC_CYCLES))
        timer_ff <= timer_ff + 20'h00001;
      if (ref_lost || test_mode)
        sync_late_ff <= 1'b0;
      else if (state_ff == cdt_pkg::CDT_ACQUIRE && timer_ff >= 20'(SYNC_CYCLES))
        sync_late_ff <= 1'b1;
      state_ff <= nxt_state;
    end
  end

  assign adj       = adj_ff;
  assign locked    = (state_ff == cdt_pkg::CDT_LOCKED);
  assign sync_late = sync_late_ff;
endmodule : cdt_lock_mon

//--- testbench/cdt_top_monitor.sv
// Purpose: Port checks for cdt_top
// Assumes: One clock domain
// Notes:   Mode checks wait for the pin synchronisers
`timescale 1ns/1ps
`include "cdt_params.svh"
module cdt_top_monitor (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        TWO_PHASE_ENABLE,
  input wire logic        INVERT_OUT1_N,
  input wire logic        TEST_SELECT,
  input wire logic        OUT_CLK_0,
  input wire logic        OUT_CLK_1,
  input wire logic        OUT_CLK_2,
  input wire logic        OUT_CLK_3,
  input wire logic        OUT_CLK_4,
  input wire logic        OUT_CLK_5,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic        HRESP
);
  logic [3:0] cfg_age_ff;
  wire        settled = cfg_age_ff[3];
  wire        rd_stat = HSEL && HTRANS[1] && HREADY && !HWRITE
                        && HADDR == {24'h0, `CDT_ADDR_STATUS};
  default clocking mon_cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // Mode pins reach the outputs three CLK cycles after they change, through the sync flops
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cfg_age_ff <= 4'h0;
    else if ($changed(INVERT_OUT1_N) || $changed(TWO_PHASE_ENABLE))
      cfg_age_ff <= 4'h0;
    else if (!settled)
      cfg_age_ff <= cfg_age_ff + 4'h1;
  end
  inv_copy_a: assert property (settled && INVERT_OUT1_N && $changed(OUT_CLK_0)
    |-> OUT_CLK_1 == OUT_CLK_0) else $error("out1 not a copy of out0");
  inv_comp_a: assert property (settled && !INVERT_OUT1_N && $changed(OUT_CLK_0)
    |-> OUT_CLK_1 != OUT_CLK_0) else $error("out1 not inverse of out0");
  phase_excl_a: assert property (settled && TWO_PHASE_ENABLE
    && $changed({OUT_CLK_4, OUT_CLK_5}) |-> !(OUT_CLK_4 && OUT_CLK_5))
    else $error("phases overlap");
  dbl_copy_a: assert property (settled && !TWO_PHASE_ENABLE && $changed(OUT_CLK_2)
    |-> OUT_CLK_4 == OUT_CLK_2 && OUT_CLK_5 == OUT_CLK_3) else $error("out4 out5 not 2x");
  dbl_pair_a: assert property ($changed(OUT_CLK_2) |-> OUT_CLK_3 == OUT_CLK_2)
    else $error("out2 and out3 differ");
  rise_sync_a: assert property ($rose(OUT_CLK_0) |-> OUT_CLK_2 && OUT_CLK_3)
    else $error("double rate low at out0 rise");
  mode_stat_a: assert property (rd_stat && $past(TEST_SELECT, 4) == TEST_SELECT
    |=> HRDATA[2] == $past(TEST_SELECT)) else $error("status mode bit wrong");
  bus_okay_a: assert property (HREADYOUT |=> HREADYOUT && !HRESP)
    else $error("bus not ready or error");
  cover property (TWO_PHASE_ENABLE && $rose(OUT_CLK_5));
  cover property (!INVERT_OUT1_N && $rose(OUT_CLK_1));
  cover property (TEST_SELECT && $rose(OUT_CLK_0));
endmodule : cdt_top_monitor

bind cdt_top cdt_top_monitor cdt_top_monitor_inst (
  .CLK(CLK), .ARST_N(ARST_N), .TWO_PHASE_ENABLE(TWO_PHASE_ENABLE),
  .INVERT_OUT1_N(INVERT_OUT1_N), .TEST_SELECT(TEST_SELECT), .OUT_CLK_0(OUT_CLK_0),
  .OUT_CLK_1(OUT_CLK_1), .OUT_CLK_2(OUT_CLK_2), .OUT_CLK_3(OUT_CLK_3), .OUT_CLK_4(OUT_CLK_4),
  .OUT_CLK_5(OUT_CLK_5), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP));

//--- testbench/cdt_board.sv
// Purpose: Board side: reference source and feedback trace
// Assumes: Reference edges land on CLK edges
// Notes:   Feedback is a fixed delay of output zero
`timescale 1ns/1ps
module cdt_board #(
  parameter int HALF = 40,
  parameter int DLY  = 2
) (
  input  wire logic clk,
  input  wire logic q0,
  output logic      ref_clk,
  output logic      fb
);
  int         cnt;
  logic [7:0] pipe;
  initial
  begin
    cnt = 0;
    ref_clk = 1'b0;
    pipe = 8'h00;
  end
  always @(posedge clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      ref_clk <= ~ref_clk;
    pipe <= {pipe[6:0], q0};
  end
  // Never gated: the trace follows output zero at all times
  assign fb = pipe[DLY - 1];
endmodule : cdt_board

//--- testbench/cdt_top_tb.sv
// Purpose: Self-checking bench for cdt_top
// Assumes: Board model feeds output zero back
// Notes:   Short lock limit keeps the run brief
`timescale 1ns/1ps
`include "cdt_params.svh"
module cdt_top_tb;
  localparam int SYNC = 3000;
  logic        clk, arst_n, en2, inv_n, tsel, tstep, hsel, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd;
  wire         ref_clk, fb, hrdy, hresp;
  wire  [5:0]  q;
  wire  [31:0] hrdata;
  int          n_fail, comparisons;
  cdt_top #(.SYNC_CYCLES(SYNC)) cdt_top_inst (
    .CLK(clk), .ARST_N(arst_n), .REFERENCE_CLOCK_IN(ref_clk), .FEEDBACK_IN(fb),
    .TWO_PHASE_ENABLE(en2), .INVERT_OUT1_N(inv_n), .TEST_SELECT(tsel),
    .TEST_STEP_CLOCK(tstep), .OUT_CLK_0(q[0]), .OUT_CLK_1(q[1]), .OUT_CLK_2(q[2]),
    .OUT_CLK_3(q[3]), .OUT_CLK_4(q[4]), .OUT_CLK_5(q[5]), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp));
  cdt_board cdt_board_inst (.clk(clk), .q0(q[0]), .ref_clk(ref_clk), .fb(fb));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic pulse;
    tstep <= 1'b1;
    repeat (4) @(posedge clk);
    tstep <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
  task automatic t_regs;
    ahb(1'b0, `CDT_ADDR_CONFIG, 32'h0);
    chk(rd, {29'h0, `CDT_GRADE_RST});
    ahb(1'b1, `CDT_ADDR_CONFIG, 32'h7);
    ahb(1'b0, `CDT_ADDR_CONFIG, 32'h0);
    chk(rd, {29'h0, `CDT_GRADE_RST});
    ahb(1'b1, `CDT_ADDR_PERIOD, 32'h0);
    ahb(1'b0, `CDT_ADDR_PERIOD, 32'h0);
    chk(rd[15:0], 16'h0050);
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
  endtask : t_regs
  task automatic t_start;
    logic [5:0] snap;
    int         k = 0;
    tsel <= 1'b1;
    repeat (8) @(posedge clk);
    snap = q;
    repeat (100) @(posedge clk);
    chk(q, snap);
    while (k < 40 && q[0] !== 1'b1)
    begin
      pulse;
      k++;
    end
    chk(k <= 16, 1'b1);
    ahb(1'b0, `CDT_ADDR_STATUS, 32'h0);
    chk(rd[2], 1'b1);
  endtask : t_start
  task automatic t_grade(input logic [2:0] g, input int n);
    int   c0 = 0, c4 = 0, c5 = 0, r2 = 0, bad = 0;
    logic p = 1'b1;
    ahb(1'b1, `CDT_ADDR_CONFIG, {29'h0, g});
    ahb(1'b0, `CDT_ADDR_CONFIG, 32'h0);
    chk(rd, {29'h0, g});
    inv_n <= g[0];
    en2 <= g[1];
    // Grade change may land mid-cycle, so find a fresh out0 rise
    for (int k = 0; k < 48 && !(q[0] === 1'b1 && p === 1'b0); k++)
    begin
      p = q[0];
      pulse;
    end
    for (int j = 0; j < n; j++)
    begin
      c0 += q[0];
      c4 += q[4];
      c5 += q[5];
      r2 += q[2] & !p;
      bad += q[1] !== (q[0] ^ !g[0]);
      p = q[2];
      pulse;
    end
    chk(c0, n / 2);
    chk(q[0], 1'b1);
    chk(r2, 2);
    chk(bad, 0);
    chk(c4, g[1] ? n / 4 - 1 : n / 2);
    chk(c5, g[1] ? n / 4 - 1 : n / 2);
  endtask : t_grade
  task automatic t_lock;
    int   k = 0, r0 = 0, r2 = 0;
    logic p = 1'b1, l2 = 1'b1;
    tsel <= 1'b0;
    tstep <= 1'b1;
    en2 <= 1'b0;
    ahb(1'b1, `CDT_ADDR_CONFIG, {29'h0, `CDT_GRADE_25});
    rd = 32'h0;
    while (k < SYNC && rd[0] !== 1'b1)
    begin
      ahb(1'b0, `CDT_ADDR_STATUS, 32'h0);
      k += 2;
    end
    chk(rd[1:0], 2'h1);
    for (k = 0; k < 200 && !(q[0] === 1'b1 && p === 1'b0); k++)
    begin
      p = q[0];
      @(negedge clk);
    end
    // 780 cycles avoids a window edge on the 80-cycle period
    p = 1'b1;
    repeat (780)
    begin
      @(negedge clk);
      r0 += q[0] & !p;
      r2 += q[2] & !l2;
      p = q[0];
      l2 = q[2];
    end
    chk(r0, 9);
    chk(r2, 19);
  endtask : t_lock
  task automatic test_done;
    $display("checks %0d errors %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial
  begin
    {arst_n, en2, tsel, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {inv_n, tstep} = 2'h3;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (200) @(posedge clk);
    t_regs;
    t_start;
    t_grade(`CDT_GRADE_20, `CDT_STEPS_20);
    t_grade(`CDT_GRADE_25, `CDT_STEPS_25);
    t_grade(`CDT_GRADE_33, `CDT_STEPS_33);
    t_grade(`CDT_GRADE_40, `CDT_STEPS_40);
    t_grade(`CDT_GRADE_50, `CDT_STEPS_50);
    t_lock;
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end
endmodule : cdt_top_tb
